// >>> inc/width_fault_pkg.sv
// Constants shared by the translation-entry decode block.
package width_fault_pkg;
  localparam int ENTRY_W          = 64;
  localparam int ADDR_W           = 64;
  localparam int PRESENT_BIT      = 0;
  localparam int MUTE_BIT         = 1;
  localparam int WIDTH_LO         = 2;
  localparam int WIDTH_HI         = 4;
  localparam int TTYPE_LO         = 6;
  localparam int TTYPE_HI         = 8;
  localparam int EXT_USED_BIT     = 10;
  localparam int EXT_USED_EN_BIT  = 11;
  localparam int FLT_SUPP_BIT     = 0;
  localparam int FLT_PRESENT_BIT  = 1;
  localparam int FLT_RANGE_BIT    = 2;
  localparam int FLT_RSVD_BIT     = 3;
  localparam int FLT_W            = 4;

  localparam logic [2:0] WIDTH_RSVD0 = 3'h0;
  localparam logic [2:0] WIDTH_39    = 3'h1;
  localparam logic [2:0] WIDTH_48    = 3'h2;
  localparam logic [2:0] WIDTH_57    = 3'h3;

  localparam logic [6:0] BITS_39 = 7'h27;
  localparam logic [6:0] BITS_48 = 7'h30;
  localparam logic [6:0] BITS_57 = 7'h39;
  localparam logic [2:0] LEVELS_3 = 3'h3;
  localparam logic [2:0] LEVELS_4 = 3'h4;
  localparam logic [2:0] LEVELS_5 = 3'h5;

  localparam logic [2:0] TT_STAGE1 = 3'h1;
  localparam logic [2:0] TT_STAGE2 = 3'h2;
  localparam logic [2:0] TT_NESTED = 3'h3;
  localparam logic [2:0] TT_PASS   = 3'h4;

  localparam logic [3:0] STATUS_EVENTS_W_MASK = 4'hF;
  localparam logic [1:0] REG_STATUS = 2'h0;
  localparam logic [1:0] REG_CLEAR  = 2'h1;
  localparam logic [1:0] REG_ENABLE = 2'h2;
  localparam logic [1:0] REG_CAPS   = 2'h3;
  localparam logic [3:0] CAPS_RESET = 4'h0;
endpackage : width_fault_pkg

// >>> rtl/width_decode.sv
// Combinational decode of the guest-width code into address bits and walk depth.
`timescale 1ns/10ps
`default_nettype none
module width_decode (
  input  wire logic [2:0] guest_width_code,
  input  wire logic       stage2_supported,
  output logic [6:0]      adjusted_guest_width,
  output logic [2:0]      walk_levels,
  output logic            width_reserved
);
  always_comb begin
    adjusted_guest_width = width_fault_pkg::BITS_39;
    walk_levels          = width_fault_pkg::LEVELS_3;
    width_reserved       = 1'b0;
    unique case (guest_width_code)
      width_fault_pkg::WIDTH_39: begin
        adjusted_guest_width = width_fault_pkg::BITS_39;
        walk_levels          = width_fault_pkg::LEVELS_3;
      end
      width_fault_pkg::WIDTH_48: begin
        adjusted_guest_width = width_fault_pkg::BITS_48;
        walk_levels          = width_fault_pkg::LEVELS_4;
      end
      width_fault_pkg::WIDTH_57: begin
        adjusted_guest_width = width_fault_pkg::BITS_57;
        walk_levels          = width_fault_pkg::LEVELS_5;
      end
      width_fault_pkg::WIDTH_RSVD0: begin
        width_reserved = stage2_supported;
      end
      default: begin
        width_reserved = 1'b1;
      end
    endcase
  end
endmodule // width_decode
`default_nettype wire

// >>> rtl/stage1_used_update.sv
// Read-modify-write sequencer that sets the extended-used flag of a first-stage entry.
`timescale 1ns/10ps
`default_nettype none
module stage1_used_update (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        access_valid,
  input  wire logic [63:0] access_entry_addr,
  input  wire logic        flag_active,
  output logic             access_ready,
  output logic             access_done,
  output logic             mem_lock_req,
  input  wire logic        mem_lock_grant,
  output logic             mem_rd,
  output logic             mem_wr,
  output logic [63:0]      mem_addr,
  output logic [63:0]      mem_wdata,
  input  wire logic        mem_rvalid,
  input  wire logic [63:0] mem_rdata,
  input  wire logic        mem_wack,
  output logic             flag_set_event
);
  typedef enum logic [2:0] {IDLE, LOCK, READ, WAIT_RD, WRITE, WAIT_WR, DONE} state_type;
  typedef struct packed {
    state_type   st;
    logic [63:0] addr;
    logic [63:0] data;
    logic        done;
    logic        setev;
  } regs_type;
  regs_type s_r;
  regs_type s_nxt;

  always_comb begin
    s_nxt       = s_r;
    s_nxt.done  = 1'b0;
    s_nxt.setev = 1'b0;
    unique case (s_r.st)
      IDLE: begin
        if (access_valid) begin
          s_nxt.addr = access_entry_addr;
          // When the flag is not active the access needs no memory update.
          s_nxt.st   = flag_active ? LOCK : DONE;
        end
      end
      LOCK: begin
        if (mem_lock_grant) begin
          s_nxt.st = READ;
        end
      end
      READ: begin
        s_nxt.st = WAIT_RD;
      end
      WAIT_RD: begin
        if (mem_rvalid) begin
          s_nxt.data = mem_rdata;
          s_nxt.data[width_fault_pkg::EXT_USED_BIT] = 1'b1;
          s_nxt.setev = ~mem_rdata[width_fault_pkg::EXT_USED_BIT];
          s_nxt.st = WRITE;
        end
      end
      WRITE: begin
        s_nxt.st = WAIT_WR;
      end
      WAIT_WR: begin
        if (mem_wack) begin
          s_nxt.st = DONE;
        end
      end
      DONE: begin
        s_nxt.done = 1'b1;
        s_nxt.st   = IDLE;
      end
      // The eighth state code is unused; recover to idle if it is ever reached.
      default: begin
        s_nxt.st = IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_r <= '{st: IDLE, addr: 64'h0, data: 64'h0, done: 1'b0, setev: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  // The lock is held from read through write-back so no other agent's update is lost.
  assign mem_lock_req   = (s_r.st != IDLE) && (s_r.st != DONE);
  assign access_ready   = (s_r.st == IDLE);
  assign access_done    = s_r.done;
  assign mem_rd         = (s_r.st == READ);
  assign mem_wr         = (s_r.st == WRITE);
  assign mem_addr       = s_r.addr;
  assign mem_wdata      = s_r.data;
  assign flag_set_event = s_r.setev;
endmodule // stage1_used_update
`default_nettype wire

// >>> rtl/entry_width_check.sv
// Decode of the low context-entry fields, range check, fault reporting and register port.
//
// Summary of operation
// - Bits 4:2 of the entry select the adjusted guest width for second-stage walks.
// - Code 001b means 39 bits and 3 levels, 010b 48 bits and 4 levels, 011b 57 bits and 5 levels.
// - Code 000b is reserved when second-stage is supported, and 100b to 111b are always reserved.
// - The width field is ignored for first-stage-only and pass-through translation types.
// - A second-stage request above two to the width minus one is blocked as a translation fault.
// - The fault-mute bit at position 1 suppresses reporting of non-recoverable faults when set.
// - The fault-mute bit is evaluated whether or not the entry is present.
// - With bit 0 clear the entry is not present and only the mute bit counts.
// - With the extended-used enable set, bit 10 of first-stage entries is set atomically on access.
// - The extended-used flag is ignored if unsupported or if the entry clears its enable.
// - A capability bit reports first-stage 1-GByte page support.
// - Type codes 001b, 010b, 011b and 100b mean first-stage, second-stage, nested and pass-through.
`timescale 1ns/10ps
`default_nettype none
module entry_width_check #(
  parameter logic [4:0] SUPPORTED_WIDTH_MASK = 5'h0E
) (
  input  wire logic        clk,
  input  wire logic        rst,
  // Register port.
  input  wire logic [1:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata,
  output logic             irq,
  // Request check.
  input  wire logic        req_valid,
  input  wire logic [63:0] req_entry,
  input  wire logic [63:0] req_addr,
  output logic             resp_valid,
  output logic             resp_block,
  output logic             resp_fault_report,
  output logic [2:0]       resp_translation_type,
  output logic [6:0]       resp_width,
  output logic [2:0]       resp_levels,
  output logic [4:0]       supported_width_mask,
  // First-stage entry access.
  input  wire logic        s1_access_valid,
  input  wire logic [63:0] s1_entry_addr,
  input  wire logic        s1_access_enable,
  output logic             s1_access_ready,
  output logic             s1_access_done,
  output logic             mem_lock_req,
  input  wire logic        mem_lock_grant,
  output logic             mem_rd,
  output logic             mem_wr,
  output logic [63:0]      mem_addr,
  output logic [63:0]      mem_wdata,
  input  wire logic        mem_rvalid,
  input  wire logic [63:0] mem_rdata,
  input  wire logic        mem_wack
);

  ////////////////////////////////////////////////////////////////////////////
  // Field extraction.

  logic [2:0] guest_width_code;
  logic [2:0] translation_type_select;
  logic       fault_report_mute;
  logic       present;
  logic [6:0] adjusted_guest_width;
  logic [2:0] walk_levels;
  logic       width_reserved;
  logic       stage2_supported;
  logic       extended_used_supported;
  logic       stage1_huge_page_support;
  logic       flag_set_event;

  assign guest_width_code        = req_entry[width_fault_pkg::WIDTH_HI:width_fault_pkg::WIDTH_LO];
  assign translation_type_select = req_entry[width_fault_pkg::TTYPE_HI:width_fault_pkg::TTYPE_LO];
  assign fault_report_mute       = req_entry[width_fault_pkg::MUTE_BIT];
  assign present                 = req_entry[width_fault_pkg::PRESENT_BIT];

  width_decode u_width_decode (
    .guest_width_code     (guest_width_code),
    .stage2_supported     (stage2_supported),
    .adjusted_guest_width (adjusted_guest_width),
    .walk_levels          (walk_levels),
    .width_reserved       (width_reserved)
  );

  // True when the address has any bit set at or above the selected width.
  function automatic logic above_width(input logic [63:0] a, input logic [6:0] w);
    logic [63:0] lim;
    lim = (64'h1 << w) - 64'h1;
    return a > lim;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State.

  typedef struct packed {
    logic        resp_valid;
    logic        resp_block;
    logic        resp_report;
    logic [2:0]  ttype;
    logic [6:0]  width;
    logic [2:0]  levels;
    logic [3:0]  status;
    logic [3:0]  enable;
    logic [3:0]  caps;
    logic [31:0] rdata;
  } regs_type;
  regs_type s_r;
  regs_type s_nxt;

  logic       stage2_path;
  logic       uses_width;
  logic       bad_type;
  logic       range_fault;
  logic       any_fault;
  logic [3:0] events;

  always_comb begin
    // Second-stage walks happen for second-stage-only and nested types.
    stage2_path = (translation_type_select == width_fault_pkg::TT_STAGE2) ||
                  (translation_type_select == width_fault_pkg::TT_NESTED);
    // First-stage-only and pass-through never look at the width field.
    uses_width  = stage2_path;
    bad_type    = !((translation_type_select == width_fault_pkg::TT_STAGE1) || stage2_path ||
                    (translation_type_select == width_fault_pkg::TT_PASS));
    range_fault = uses_width && !width_reserved && above_width(req_addr, adjusted_guest_width);
    any_fault   = !present || bad_type || (uses_width && width_reserved) || range_fault;
    events      = 4'h0;
    if (req_valid) begin
      events[width_fault_pkg::FLT_PRESENT_BIT] = !present;
      events[width_fault_pkg::FLT_RANGE_BIT]   = present && range_fault;
      events[width_fault_pkg::FLT_RSVD_BIT]    = present && (bad_type || (uses_width && width_reserved));
      events[width_fault_pkg::FLT_SUPP_BIT]    = flag_set_event;
    end else begin
      events[width_fault_pkg::FLT_SUPP_BIT]    = flag_set_event;
    end
    // Muted entries still block the request but raise no fault status.
    if (fault_report_mute) begin
      events[width_fault_pkg::FLT_RSVD_BIT:width_fault_pkg::FLT_PRESENT_BIT] = 3'h0;
    end

    s_nxt            = s_r;
    s_nxt.resp_valid = req_valid;
    if (req_valid) begin
      s_nxt.resp_block  = any_fault;
      s_nxt.resp_report = any_fault && !fault_report_mute;
      s_nxt.ttype       = translation_type_select;
      s_nxt.width       = uses_width ? adjusted_guest_width : 7'h0;
      s_nxt.levels      = uses_width ? walk_levels : 3'h0;
    end

    // Set beats clear for every sticky bit.
    if (reg_wr && reg_addr == width_fault_pkg::REG_CLEAR) begin
      s_nxt.status = s_r.status & ~reg_wdata[3:0];
    end
    s_nxt.status = s_nxt.status | events;
    if (reg_wr && reg_addr == width_fault_pkg::REG_ENABLE) begin
      s_nxt.enable = reg_wdata[3:0] & width_fault_pkg::STATUS_EVENTS_W_MASK;
    end
    if (reg_wr && reg_addr == width_fault_pkg::REG_CAPS) begin
      s_nxt.caps = reg_wdata[3:0];
    end

    s_nxt.rdata = 32'h0;
    if (reg_rd) begin
      unique case (reg_addr)
        width_fault_pkg::REG_STATUS: s_nxt.rdata = {28'h0, s_r.status};
        width_fault_pkg::REG_CLEAR:  s_nxt.rdata = 32'h0;
        width_fault_pkg::REG_ENABLE: s_nxt.rdata = {28'h0, s_r.enable};
        width_fault_pkg::REG_CAPS:   s_nxt.rdata = {23'h0, SUPPORTED_WIDTH_MASK, s_r.caps[3],
                                                    stage1_huge_page_support, extended_used_supported,
                                                    stage2_supported};
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_r <= '{resp_valid: 1'b0, resp_block: 1'b0, resp_report: 1'b0, ttype: 3'h0, width: 7'h0,
               levels: 3'h0, status: 4'h0, enable: 4'h0, caps: width_fault_pkg::CAPS_RESET, rdata: 32'h0};
    end else begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Capabilities and first-stage flag update.

  assign stage2_supported         = s_r.caps[0];
  assign extended_used_supported  = s_r.caps[1];
  assign stage1_huge_page_support = s_r.caps[2];

  stage1_used_update u_used_update (
    .clk               (clk),
    .rst               (rst),
    .access_valid      (s1_access_valid),
    .access_entry_addr (s1_entry_addr),
    .flag_active       (extended_used_supported && s1_access_enable),
    .access_ready      (s1_access_ready),
    .access_done       (s1_access_done),
    .mem_lock_req      (mem_lock_req),
    .mem_lock_grant    (mem_lock_grant),
    .mem_rd            (mem_rd),
    .mem_wr            (mem_wr),
    .mem_addr          (mem_addr),
    .mem_wdata         (mem_wdata),
    .mem_rvalid        (mem_rvalid),
    .mem_rdata         (mem_rdata),
    .mem_wack          (mem_wack),
    .flag_set_event    (flag_set_event)
  );

  assign reg_rdata             = s_r.rdata;
  assign irq                   = |(s_r.status & s_r.enable);
  assign resp_valid            = s_r.resp_valid;
  assign resp_block            = s_r.resp_block;
  assign resp_fault_report     = s_r.resp_report;
  assign resp_translation_type = s_r.ttype;
  assign resp_width            = s_r.width;
  assign resp_levels           = s_r.levels;
  assign supported_width_mask  = SUPPORTED_WIDTH_MASK;

endmodule // entry_width_check
`default_nettype wire

// >>> verif/entry_check_monitor.sv
// Port-level assertions for the entry decode block.
`timescale 1ns/10ps
`default_nettype none
module entry_check_monitor (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        req_valid,
  input wire logic [63:0] req_entry,
  input wire logic [63:0] req_addr,
  input wire logic        resp_valid,
  input wire logic        resp_block,
  input wire logic        resp_fault_report,
  input wire logic [6:0]  resp_width,
  input wire logic [2:0]  resp_levels,
  input wire logic        mem_lock_req,
  input wire logic        mem_wr,
  input wire logic [63:0] mem_wdata
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_live(tt); req_valid && req_entry[0] && req_entry[8:6] == tt; endsequence
  sequence s_w39; s_live(3'h2) ##0 req_entry[4:2] == 3'h1; endsequence
  property p_resp_next; req_valid |=> resp_valid; endproperty
  a_resp_next: assert property (p_resp_next) else $error("no response one cycle after request");
  property p_w39; s_w39 ##0 req_addr[63:39] == 25'h0 |=> resp_width == 7'h27 && resp_levels == 3'h3; endproperty
  a_w39: assert property (p_w39) else $error("wrong width or depth for code 1");
  property p_rsvd; s_live(3'h2) ##0 req_entry[4] |=> resp_block; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved width code not blocked");
  property p_ignore; s_live(3'h1) or s_live(3'h4) |=> resp_width == 7'h00 && resp_levels == 3'h0; endproperty
  a_ignore: assert property (p_ignore) else $error("width used on a type that ignores it");
  property p_range; s_w39 ##0 req_addr[63:39] != 25'h0 |=> resp_block; endproperty
  a_range: assert property (p_range) else $error("address beyond width not blocked");
  property p_mute; req_valid |=> resp_fault_report == (resp_block && !$past(req_entry[1])); endproperty
  a_mute: assert property (p_mute) else $error("fault report disagrees with mute bit");
  property p_absent; req_valid && !req_entry[0] |=> resp_block; endproperty
  a_absent: assert property (p_absent) else $error("absent entry not blocked");
  property p_flag; mem_wr |-> mem_wdata[10] && mem_lock_req; endproperty
  a_flag: assert property (p_flag) else $error("write-back without flag or lock");
endmodule // entry_check_monitor
bind entry_width_check entry_check_monitor u_monitor (
  .clk               (clk),
  .rst               (rst),
  .req_valid         (req_valid),
  .req_entry         (req_entry),
  .req_addr          (req_addr),
  .resp_valid        (resp_valid),
  .resp_block        (resp_block),
  .resp_fault_report (resp_fault_report),
  .resp_width        (resp_width),
  .resp_levels       (resp_levels),
  .mem_lock_req      (mem_lock_req),
  .mem_wr            (mem_wr),
  .mem_wdata         (mem_wdata)
);
`default_nettype wire

// >>> verif/mem_model.sv
// Behavioural memory holding one first-stage entry behind a lock, read and write port.
`timescale 1ns/10ps
`default_nettype none
module mem_model #(
  parameter logic [63:0] STORED_INIT = 64'h0
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [3:0]  delay,
  input  wire logic        mem_lock_req,
  input  wire logic        mem_rd,
  input  wire logic        mem_wr,
  input  wire logic [63:0] mem_wdata,
  output logic             mem_lock_grant,
  output logic             mem_rvalid,
  output logic [63:0]      mem_rdata,
  output logic             mem_wack,
  output logic [63:0]      stored
);
  logic [3:0] cnt;
  logic       rd_pend;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mem_lock_grant <= 1'b0;
      mem_rvalid <= 1'b0;
      mem_rdata <= 64'h0;
      mem_wack <= 1'b0;
      stored <= STORED_INIT;
      cnt <= 4'h0;
      rd_pend <= 1'b0;
    end else begin
      // Between answers the data lines toggle, so a stale word is never mistaken for a read.
      mem_rdata <= ~mem_rdata;
      mem_rvalid <= 1'b0;
      mem_wack <= mem_wr;
      cnt <= ((mem_lock_req && !mem_lock_grant) || rd_pend) ? cnt + 4'h1 : 4'h0;
      mem_lock_grant <= mem_lock_req && (mem_lock_grant || cnt >= delay);
      rd_pend <= mem_rd || (rd_pend && cnt < delay);
      if (rd_pend && cnt >= delay) begin
        mem_rvalid <= 1'b1;
        mem_rdata <= stored;
      end
      if (mem_wr) begin
        stored <= mem_wdata;
      end
    end
  end
endmodule // mem_model
`default_nettype wire

// >>> verif/entry_width_check_test.sv
// Self-checking bench for the entry decode block and its first-stage update port.
`timescale 1ns/10ps
`default_nettype none
module entry_width_check_test;
  localparam logic [63:0] INIT = 64'h0123_4567_89AB_C003;
  logic        clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, req_valid = 1'b0;
  logic        s1_access_valid = 1'b0, s1_access_enable = 1'b0;
  logic [1:0]  reg_addr = 2'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic [63:0] req_entry = 64'h0, req_addr = 64'h0, s1_entry_addr = 64'h0;
  logic [3:0]  delay = 4'h0;
  logic        irq, resp_valid, resp_block, resp_fault_report, s1_access_ready, s1_access_done;
  logic        mem_lock_req, mem_lock_grant, mem_rd, mem_wr, mem_rvalid, mem_wack;
  logic [31:0] reg_rdata;
  logic [63:0] mem_addr, mem_wdata, mem_rdata, stored;
  logic [6:0]  resp_width;
  logic [2:0]  resp_translation_type, resp_levels;
  logic [4:0]  supported_width_mask;
  int          err_count = 0, num_checks = 0;
  entry_width_check DUT (
    .clk                   (clk),
    .rst                   (rst),
    .reg_addr              (reg_addr),
    .reg_wdata             (reg_wdata),
    .reg_wr                (reg_wr),
    .reg_rd                (reg_rd),
    .reg_rdata             (reg_rdata),
    .irq                   (irq),
    .req_valid             (req_valid),
    .req_entry             (req_entry),
    .req_addr              (req_addr),
    .resp_valid            (resp_valid),
    .resp_block            (resp_block),
    .resp_fault_report     (resp_fault_report),
    .resp_translation_type (resp_translation_type),
    .resp_width            (resp_width),
    .resp_levels           (resp_levels),
    .supported_width_mask  (supported_width_mask),
    .s1_access_valid       (s1_access_valid),
    .s1_entry_addr         (s1_entry_addr),
    .s1_access_enable      (s1_access_enable),
    .s1_access_ready       (s1_access_ready),
    .s1_access_done        (s1_access_done),
    .mem_lock_req          (mem_lock_req),
    .mem_lock_grant        (mem_lock_grant),
    .mem_rd                (mem_rd),
    .mem_wr                (mem_wr),
    .mem_addr              (mem_addr),
    .mem_wdata             (mem_wdata),
    .mem_rvalid            (mem_rvalid),
    .mem_rdata             (mem_rdata),
    .mem_wack              (mem_wack)
  );
  mem_model #(.STORED_INIT(INIT)) u_mem (
    .clk            (clk),
    .rst            (rst),
    .delay          (delay),
    .mem_lock_req   (mem_lock_req),
    .mem_rd         (mem_rd),
    .mem_wr         (mem_wr),
    .mem_wdata      (mem_wdata),
    .mem_lock_grant (mem_lock_grant),
    .mem_rvalid     (mem_rvalid),
    .mem_rdata      (mem_rdata),
    .mem_wack       (mem_wack),
    .stored         (stored)
  );
  initial begin
    forever #50 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic regop(input logic rd, input logic [1:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_rd <= rd;
    reg_wr <= !rd;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_rd <= 1'b0;
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic req(input logic [63:0] e, input logic [63:0] a);
    @(posedge clk);
    req_valid <= 1'b1;
    req_entry <= e;
    req_addr <= a;
    @(posedge clk);
    req_valid <= 1'b0;
    #1;
    chk("resp_valid", 64'h1, 64'(resp_valid));
  endtask
  // Waits are bounded so a stuck sequencer shows as a mismatch instead of a hang.
  task automatic s1(input logic en, input logic [3:0] d);
    chk("s1_access_ready", 64'h1, 64'(s1_access_ready));
    @(posedge clk);
    delay <= d;
    s1_access_valid <= 1'b1;
    s1_entry_addr <= 64'h42000;
    s1_access_enable <= en;
    @(posedge clk);
    s1_access_valid <= 1'b0;
    #1;
    for (int i = 0; i < 40 && s1_access_done !== 1'b1; i++) @(posedge clk) #1;
    chk("s1_access_done", 64'h1, 64'(s1_access_done));
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    regop(1'b1, 2'h3, 32'h0);
    chk("caps", 64'hE0, 64'(reg_rdata));
    chk("mask", 64'h0E, 64'(supported_width_mask));
    regop(1'b0, 2'h3, 32'h7);
    regop(1'b1, 2'h3, 32'h0);
    chk("caps", 64'hE7, 64'(reg_rdata));
    regop(1'b0, 2'h2, 32'hF);
    $display("test regs done");
  endtask
  task automatic t_decode();
    for (int c = 0; c < 8; c++) begin
      req({55'h0, 3'h2, 1'b0, 3'(c), 2'h1}, 64'h0);
      chk("block", 64'(c == 0 || c > 3), 64'(resp_block));
      if (c > 0 && c < 4) begin
        chk("width", 64'(30 + 9 * c), 64'(resp_width));
        chk("levels", 64'(c + 2), 64'(resp_levels));
      end
    end
    for (int t = 0; t < 8; t++) begin
      req({55'h0, 3'(t), 1'b0, 3'h7, 2'h1}, 64'h0);
      chk("type", 64'(t), 64'(resp_translation_type));
      chk("block", 64'(t != 1 && t != 4), 64'(resp_block));
    end
    regop(1'b0, 2'h3, 32'h6);
    req({55'h0, 3'h2, 1'b0, 3'h0, 2'h1}, 64'h0);
    chk("block", 64'h0, 64'(resp_block));
    $display("test decode done");
  endtask
  task automatic t_fault();
    regop(1'b0, 2'h1, 32'hF);
    req({55'h0, 3'h7, 1'b0, 3'h7, 2'h2}, 64'h0);
    chk("report", 64'h0, 64'(resp_fault_report));
    chk("block", 64'h1, 64'(resp_block));
    chk("irq", 64'h0, 64'(irq));
    req({55'h0, 3'h7, 1'b0, 3'h7, 2'h0}, 64'h0);
    chk("report", 64'h1, 64'(resp_fault_report));
    req({55'h0, 3'h2, 1'b0, 3'h1, 2'h1}, 64'h0000_007F_FFFF_FFFF);
    chk("block", 64'h0, 64'(resp_block));
    req({55'h0, 3'h2, 1'b0, 3'h1, 2'h1}, 64'h0000_0080_0000_0000);
    chk("block", 64'h1, 64'(resp_block));
    regop(1'b1, 2'h0, 32'h0);
    chk("status", 64'h6, 64'(reg_rdata));
    chk("irq", 64'h1, 64'(irq));
    regop(1'b0, 2'h2, 32'h0);
    chk("irq", 64'h0, 64'(irq));
    regop(1'b0, 2'h1, 32'hF);
    regop(1'b0, 2'h2, 32'hF);
    chk("irq", 64'h0, 64'(irq));
    $display("test fault done");
  endtask
  task automatic t_s1();
    regop(1'b0, 2'h3, 32'h5);
    s1(1'b1, 4'h0);
    chk("entry", INIT, stored);
    regop(1'b0, 2'h3, 32'h7);
    s1(1'b0, 4'h2);
    chk("entry", INIT, stored);
    s1(1'b1, 4'h3);
    chk("entry", INIT | 64'h400, stored);
    chk("mem_addr", 64'h42000, mem_addr);
    regop(1'b1, 2'h0, 32'h0);
    chk("status", 64'h1, 64'(reg_rdata));
    $display("test first-stage done");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_decode();
    t_fault();
    t_s1();
    complete_run();
  end
  initial begin
    repeat (3000) @(posedge clk);
    err_count++;
    complete_run();
  end
endmodule // entry_width_check_test
`default_nettype wire
